// file: design/rss_consts.svh
// Constants for the read-side active state block
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define RSS_OFS_OPTIONS 8'h00
`define RSS_OFS_SRC_PTR 8'h04
`define RSS_OFS_COUNTS 8'h08
`define RSS_OFS_DST_PTR 8'h0c
`define RSS_OFS_STRIDES 8'h10
`define RSS_OFS_IRQ_STATUS 8'h14
`define RSS_OFS_IRQ_MASK 8'h18
`define RSS_OFS_CONTROL 8'h1c

// ----------------------------------------
// Options field positions
// ----------------------------------------
`define RSS_OPT_LINK_BIT 22
`define RSS_OPT_IRQ_BIT 20
`define RSS_OPT_CODE_LSB 12
`define RSS_OPT_SIZE_LSB 8
`define RSS_OPT_RANK_LSB 4
`define RSS_OPT_DAM_BIT 1
`define RSS_OPT_SAM_BIT 0
`define RSS_OPT_RW_MASK 32'h0050_0000
`define RSS_OPT_VALID_MASK 32'h0053_f773

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define RSS_IRQ_DONE_BIT 0
`define RSS_IRQ_BADSIZE_BIT 1
`define RSS_IRQ_WIDTH 2

// ----------------------------------------
// Reset values and size limits
// ----------------------------------------
`define RSS_RESET_WORD 32'h0000_0000
`define RSS_SIZE_MAX 3'h4
`define RSS_BURST_MAX 16'h0040

`endif

// file: design/rss_pkg.sv
// Types shared by the read-side active state block
package rss_pkg;

   typedef enum logic [1:0]
   {
      RSS_IDLE = 2'b00,
      RSS_READ = 2'b01,
      RSS_DONE = 2'b10
   } rss_state_e;

endpackage

// file: design/rss_sync.sv
// Three-stage synchroniser for an external level
`timescale 1ns/1ps
module rss_sync
(
   // Clock and control
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_ce,
   // Data
   input wire logic i_async,
   output logic o_level
);

   typedef struct packed
   {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } rss_sync_s;

   rss_sync_s r;
   rss_sync_s next_r;

   always_comb
   begin
      next_r = r;
      next_r.s1 = i_async;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      // Change the level only once the later two stages agree
      if (r.s2 == r.s3)
      begin
         next_r.level = r.s3;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         r <= '0;
      end
      else if (i_ce)
      begin
         r <= next_r;
      end
   end

   assign o_level = r.level;

endmodule

// file: design/rss_step.sv
// Next read address and byte count for one read command
`timescale 1ns/1ps
`include "rss_consts.svh"
module rss_step
(
   // Current state
   input wire logic [31:0] i_ptr,
   input wire logic [31:0] i_array_base,
   input wire logic [15:0] i_bytes_left,
   input wire logic i_const_mode,
   input wire logic [2:0] i_size,
   // Result
   output logic [31:0] o_next_ptr,
   output logic [15:0] o_chunk
);

   logic [15:0] port_bytes;
   logic [15:0] limit;
   logic [31:0] span;

   always_comb
   begin
      port_bytes = 16'h0001 << i_size;
      limit = i_const_mode ? port_bytes : `RSS_BURST_MAX;
      o_chunk = (i_bytes_left < limit) ? i_bytes_left : limit;
      span = i_ptr + {16'h0000, o_chunk} - i_array_base;
      if (i_const_mode && (span >= {16'h0000, port_bytes}))
      begin
         // Constant mode wraps back to the array start at the port width
         o_next_ptr = i_array_base;
      end
      else
      begin
         o_next_ptr = i_ptr + {16'h0000, o_chunk};
      end
   end

endmodule

// file: design/rss_read_side.sv
// Read-side active state of one transfer controller channel
//
// Summary of operation
// - Hold completion link enable; when set, completion signals chaining of the code.
// - Hold completion irq enable; when set, completion raises a completion interrupt.
// - Carry a six-bit completion code, reported with each completion.
// - Fixed-port size applies only in constant mode; codes 5 to 7 reserved.
// - Present the three-bit transfer rank as programmed; 0 highest, 7 lowest.
// - Destination style 0 increments, 1 wraps at fixed-port size.
// - Source style 0 increments, 1 wraps at fixed-port size.
// - Keep a 32-bit read pointer advanced per the source addressing style.
// - Keep 16-bit arrays left, decremented as arrays are read, zero at completion.
// - Keep 16-bit first-dimension bytes left, decremented per read command.
// - Keep 16-bit source array stride, applied when moving to the next array.
// - Destination pointer word and upper stride half always read as zero.
// - State loaded by the channel controller on submit; read-only to software except the link and irq enable bits.
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "rss_consts.svh"
module rss_read_side
   import rss_pkg::*;
(
   // Clock and control
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_ce,
   // Request load from the channel controller
   input wire logic i_load,
   input wire logic [31:0] i_load_options,
   input wire logic [31:0] i_load_src,
   input wire logic [15:0] i_load_arrays,
   input wire logic [15:0] i_load_bytes,
   input wire logic [15:0] i_load_stride,
   output logic o_load_ready,
   // Read command toward memory endpoints
   output logic o_rd_valid,
   output logic [31:0] o_rd_addr,
   output logic [15:0] o_rd_bytes,
   input wire logic i_rd_ready,
   // Completion report
   output logic o_done,
   output logic [5:0] o_done_code,
   output logic o_done_link,
   output logic o_done_irq,
   // External pause pin from outside the clock domain
   input wire logic i_pause_pin,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // Interrupt
   output logic o_irq
);

   typedef struct packed
   {
      rss_state_e state;
      logic [31:0] options;
      logic [31:0] ptr;
      logic [31:0] array_base;
      logic [15:0] arrays;
      logic [15:0] bytes;
      logic [15:0] bytes_reload;
      logic [15:0] stride;
      logic rd_valid;
      logic [31:0] rd_addr;
      logic [15:0] rd_bytes;
      logic [31:0] step_ptr;
      logic done;
      logic [5:0] done_code;
      logic done_link;
      logic done_irq;
      logic [`RSS_IRQ_WIDTH-1:0] irq_status;
      logic [`RSS_IRQ_WIDTH-1:0] irq_mask;
      logic sw_pause;
      logic [31:0] rdata;
      logic irq;
      logic load_ready;
   } rss_s;

   rss_s r;
   rss_s next_r;
   logic pause_level;
   logic [31:0] step_next_ptr;
   logic [15:0] step_chunk;
   logic const_mode;
   logic [2:0] size_code;
   logic [`RSS_IRQ_WIDTH-1:0] irq_set;
   logic load_bad_size;

   // ----------------------------------------
   // Pause pin synchroniser
   // ----------------------------------------
   rss_sync u_pause_sync
   (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_ce(i_ce),
      .i_async(i_pause_pin),
      .o_level(pause_level)
   );

   // ----------------------------------------
   // Address stepping
   // ----------------------------------------
   // Size only in constant mode
   assign const_mode = r.options[`RSS_OPT_SAM_BIT];

   // Reserved size codes fall back to the widest port so a chunk never outgrows the port
   always_comb
   begin
      if (r.options[`RSS_OPT_SIZE_LSB +: 3] > `RSS_SIZE_MAX)
      begin
         size_code = `RSS_SIZE_MAX;
      end
      else
      begin
         size_code = r.options[`RSS_OPT_SIZE_LSB +: 3];
      end
   end

   rss_step u_step
   (
      .i_ptr(r.ptr),
      .i_array_base(r.array_base),
      .i_bytes_left(r.bytes),
      .i_const_mode(const_mode),
      .i_size(size_code),
      .o_next_ptr(step_next_ptr),
      .o_chunk(step_chunk)
   );

   // ----------------------------------------
   // Load checks
   // ----------------------------------------
   // Destination style is only held here; it still makes the size field count
   // Reserved size codes are flagged when either side uses constant mode
   always_comb
   begin
      load_bad_size = 1'b0;
      if (i_load_options[`RSS_OPT_SAM_BIT] || i_load_options[`RSS_OPT_DAM_BIT])
      begin
         load_bad_size = (i_load_options[`RSS_OPT_SIZE_LSB +: 3] > `RSS_SIZE_MAX);
      end
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      next_r = r;
      next_r.done = 1'b0;
      irq_set = '0;

      case (r.state)
         RSS_IDLE:
         begin
            if (i_load)
            begin
               // Reserved option bits never reach the register, so they read back as zero
               next_r.options = i_load_options & `RSS_OPT_VALID_MASK;
               next_r.ptr = i_load_src;
               next_r.array_base = i_load_src;
               next_r.arrays = i_load_arrays;
               next_r.bytes = i_load_bytes;
               next_r.bytes_reload = i_load_bytes;
               next_r.stride = i_load_stride;
               next_r.state = RSS_READ;
               // Reserved size flagged in constant mode
               irq_set[`RSS_IRQ_BADSIZE_BIT] = load_bad_size;
            end
         end
         RSS_READ:
         begin
            if (r.rd_valid)
            begin
               if (i_rd_ready)
               begin
                  next_r.rd_valid = 1'b0;
                  next_r.ptr = r.step_ptr;
                  next_r.bytes = r.bytes - r.rd_bytes;
                  if (r.bytes == r.rd_bytes)
                  begin
                     next_r.arrays = r.arrays - 16'h0001;
                     if (r.arrays > 16'h0001)
                     begin
                        next_r.array_base = r.array_base + {{16{r.stride[15]}}, r.stride};
                        next_r.ptr = r.array_base + {{16{r.stride[15]}}, r.stride};
                        next_r.bytes = r.bytes_reload;
                     end
                  end
               end
            end
            // Either count zero ends the request
            else if ((r.arrays == 16'h0000) || (r.bytes == 16'h0000))
            begin
               next_r.arrays = 16'h0000;
               next_r.bytes = 16'h0000;
               next_r.state = RSS_DONE;
            end
            else if (!pause_level && !r.sw_pause)
            begin
               next_r.rd_valid = 1'b1;
               next_r.rd_addr = r.ptr;
               next_r.rd_bytes = step_chunk;
               next_r.step_ptr = step_next_ptr;
            end
         end
         RSS_DONE:
         begin
            next_r.done = 1'b1;
            next_r.done_code = r.options[`RSS_OPT_CODE_LSB +: 6];
            next_r.done_link = r.options[`RSS_OPT_LINK_BIT];
            next_r.done_irq = r.options[`RSS_OPT_IRQ_BIT];
            irq_set[`RSS_IRQ_DONE_BIT] = r.options[`RSS_OPT_IRQ_BIT];
            next_r.state = RSS_IDLE;
         end
         default:
         begin
            next_r.state = RSS_IDLE;
         end
      endcase

      // ----------------------------------------
      // Register writes
      // ----------------------------------------
      // Pointer, count and stride words ignore writes: software only observes them
      if (i_wr)
      begin
         if (i_addr == `RSS_OFS_OPTIONS)
         begin
            // Only the two enable bits are writable; rest of the state is held
            // Built on next_r so a load in the same cycle is not undone
            next_r.options = (next_r.options & ~`RSS_OPT_RW_MASK) | (i_wdata & `RSS_OPT_RW_MASK);
         end
         else if (i_addr == `RSS_OFS_IRQ_STATUS)
         begin
            next_r.irq_status = r.irq_status & ~i_wdata[`RSS_IRQ_WIDTH-1:0];
         end
         else if (i_addr == `RSS_OFS_IRQ_MASK)
         begin
            next_r.irq_mask = i_wdata[`RSS_IRQ_WIDTH-1:0];
         end
         else if (i_addr == `RSS_OFS_CONTROL)
         begin
            // Hold only stops new commands; one already offered still waits for acceptance
            next_r.sw_pause = i_wdata[0];
         end
      end
      // Set wins over a same-cycle clear
      next_r.irq_status = next_r.irq_status | irq_set;

      // ----------------------------------------
      // Register reads
      // ----------------------------------------
      next_r.rdata = `RSS_RESET_WORD;
      if (i_rd)
      begin
         if (i_addr == `RSS_OFS_OPTIONS)
         begin
            next_r.rdata = r.options;
         end
         else if (i_addr == `RSS_OFS_SRC_PTR)
         begin
            next_r.rdata = r.ptr;
         end
         else if (i_addr == `RSS_OFS_COUNTS)
         begin
            next_r.rdata = {r.arrays, r.bytes};
         end
         else if (i_addr == `RSS_OFS_STRIDES)
         begin
            next_r.rdata = {16'h0000, r.stride};
         end
         else if (i_addr == `RSS_OFS_IRQ_STATUS)
         begin
            next_r.rdata = {30'h0, r.irq_status};
         end
         else if (i_addr == `RSS_OFS_IRQ_MASK)
         begin
            next_r.rdata = {30'h0, r.irq_mask};
         end
         else if (i_addr == `RSS_OFS_CONTROL)
         begin
            next_r.rdata = {31'h0, r.sw_pause};
         end
      end

      // ----------------------------------------
      // Registered flags
      // ----------------------------------------
      // Level interrupt follows status and mask as they stand after this cycle
      next_r.irq = |(next_r.irq_status & next_r.irq_mask);
      // Kept in a flop so the handshake output is not a decode of the state
      next_r.load_ready = (next_r.state == RSS_IDLE);
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         r <= '0;
         // Idle after reset, so a request is taken at the first edge after release
         r.load_ready <= 1'b1;
      end
      else if (i_ce)
      begin
         r <= next_r;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_load_ready = r.load_ready;
   assign o_rd_valid = r.rd_valid;
   assign o_rd_addr = r.rd_addr;
   assign o_rd_bytes = r.rd_bytes;
   assign o_done = r.done;
   assign o_done_code = r.done_code;
   assign o_done_link = r.done_link;
   assign o_done_irq = r.done_irq;
   assign o_rdata = r.rdata;
   assign o_irq = r.irq;

endmodule

// file: tb/rss_read_side_chk.sv
// Port checker for the read-side active state block
`timescale 1ns/1ps
`include "rss_consts.svh"
module rss_read_side_chk
(
   // Clock and control
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_ce,
   // Load and read command
   input wire logic i_load,
   input wire logic o_load_ready,
   input wire logic o_rd_valid,
   input wire logic [31:0] o_rd_addr,
   input wire logic [15:0] o_rd_bytes,
   input wire logic i_rd_ready,
   // Completion
   input wire logic o_done,
   input wire logic o_done_link,
   input wire logic o_done_irq,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_reset);

   chk_load_taken: assert property (i_ce && i_load && o_load_ready |=> !o_load_ready && !o_rd_valid)
      else $error("load taken but block still idle");
   chk_cmd_hold: assert property (o_rd_valid && !i_rd_ready |=>
      o_rd_valid && $stable(o_rd_addr) && $stable(o_rd_bytes))
      else $error("read command changed while stalled");
   chk_cmd_gap: assert property (o_rd_valid && i_rd_ready |=> !o_rd_valid)
      else $error("no idle cycle after accepted command");
   chk_chunk_size: assert property (o_rd_valid |-> o_rd_bytes != 16'h0 && o_rd_bytes <= `RSS_BURST_MAX)
      else $error("read command byte count out of range");
   chk_done_pulse: assert property (o_done |=> !o_done)
      else $error("completion longer than one cycle");
   chk_done_ready: assert property (o_done |-> o_load_ready && !o_rd_valid)
      else $error("completion without release for next load");
   chk_idle_quiet: assert property (o_load_ready |-> !o_rd_valid)
      else $error("read command while idle");
   chk_dst_zero: assert property (i_ce && i_rd && i_addr == `RSS_OFS_DST_PTR |=> o_rdata == 32'h0)
      else $error("destination pointer word not zero");
   chk_stride_upper: assert property (i_ce && i_rd && i_addr == `RSS_OFS_STRIDES |=> o_rdata[31:16] == 16'h0)
      else $error("upper stride half not zero");

   cover property (o_rd_valid && !i_rd_ready);
   cover property (o_done && o_done_link);
   cover property (o_done && o_done_irq);
endmodule

bind rss_read_side rss_read_side_chk u_chk (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce), .i_load(i_load),
   .o_load_ready(o_load_ready), .o_rd_valid(o_rd_valid), .o_rd_addr(o_rd_addr), .o_rd_bytes(o_rd_bytes),
   .i_rd_ready(i_rd_ready), .o_done(o_done), .o_done_link(o_done_link), .o_done_irq(o_done_irq),
   .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata));

// file: tb/rss_mem_model.sv
// Memory endpoint model that accepts read commands
`timescale 1ns/1ps
module rss_mem_model
(
   // Clock
   input wire logic i_mclk,
   // Control
   input wire logic i_slow,
   output logic o_ready
);
   // Slow mode stalls about two cycles in three to exercise command holding
   always @(posedge i_mclk)
   begin
      o_ready <= i_slow ? ($urandom % 3 == 0) : 1'b1;
   end
endmodule

// file: tb/tb_dma_tc_read_side_state.sv
// Self-checking testbench for the read-side active state block
`timescale 1ns/1ps
`include "rss_consts.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_dma_tc_read_side_state;
   logic i_mclk = 0, i_reset = 1, i_load = 0, i_rd = 0, i_wr = 0, slow = 0, rd_seen = 0, pause = 0;
   logic [31:0] i_load_options = 0, i_load_src = 0, i_wdata = 0, o_rd_addr, o_rdata, er;
   logic [15:0] i_load_arrays = 0, i_load_bytes = 0, i_load_stride = 0, o_rd_bytes;
   logic [7:0] i_addr = 0, ed;
   logic [5:0] o_done_code;
   logic [47:0] ec;
   logic o_load_ready, o_rd_valid, i_rd_ready, o_done, o_done_link, o_done_irq, o_irq;
   int fail_count = 0, checked = 0, done_cnt = 0;
   logic [47:0] exp_cmd[$];
   logic [31:0] exp_rd[$];
   logic [7:0] exp_done[$];

   initial forever #2 i_mclk = ~i_mclk;

   rss_read_side u_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(1'b1), .i_load(i_load),
      .i_load_options(i_load_options), .i_load_src(i_load_src), .i_load_arrays(i_load_arrays),
      .i_load_bytes(i_load_bytes), .i_load_stride(i_load_stride), .o_load_ready(o_load_ready),
      .o_rd_valid(o_rd_valid), .o_rd_addr(o_rd_addr), .o_rd_bytes(o_rd_bytes), .i_rd_ready(i_rd_ready),
      .o_done(o_done), .o_done_code(o_done_code), .o_done_link(o_done_link), .o_done_irq(o_done_irq),
      .i_pause_pin(pause), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .o_irq(o_irq));
   rss_mem_model u_mem (.i_mclk(i_mclk), .i_slow(slow), .o_ready(i_rd_ready));

   // ----
   // Drivers
   // ----
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
      exp_rd.push_back(e);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
   endtask

   // Expected commands are built from the array walk, wrapping to array start in constant mode
   task automatic load_req(input logic [31:0] opt, src, input logic [15:0] na, nb, st);
      logic [31:0] base, p;
      logic [15:0] left, ch, port;
      base = src;
      // Reserved size codes run at the widest port
      port = 16'h1 << ((opt[10:8] > `RSS_SIZE_MAX) ? `RSS_SIZE_MAX : opt[10:8]);
      for (int b = 0; b < na; b++)
      begin
         left = nb;
         p = base;
         while (left != 0)
         begin
            ch = opt[0] ? (left < port ? left : port) : (left < 16'd64 ? left : 16'd64);
            exp_cmd.push_back({p, ch});
            left -= ch;
            p = opt[0] ? base : p + ch;
         end
         base += {{16{st[15]}}, st};
      end
      @(posedge i_mclk);
      i_load <= 1'b1;
      i_load_options <= opt;
      i_load_src <= src;
      i_load_arrays <= na;
      i_load_bytes <= nb;
      i_load_stride <= st;
      @(posedge i_mclk);
      i_load <= 1'b0;
   endtask

   task automatic wait_done(input logic [7:0] e);
      int n;
      exp_done.push_back(e);
      n = done_cnt;
      repeat (3000) if (done_cnt == n) @(posedge i_mclk);
      `CHK(done_cnt, n + 1)
      @(posedge i_mclk);
   endtask

   task end_sim;
      $display("counts: checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ----
   // Output monitor
   // ----
   always @(posedge i_mclk)
   begin
      if (rd_seen)
      begin
         er = exp_rd.pop_front();
         `CHK(o_rdata, er)
      end
      if (o_rd_valid && i_rd_ready)
      begin
         ec = exp_cmd.pop_front();
         `CHK({o_rd_addr, o_rd_bytes}, ec)
      end
      if (o_done)
      begin
         ed = exp_done.pop_front();
         `CHK({o_done_link, o_done_irq, o_done_code}, ed)
         done_cnt++;
      end
      rd_seen <= i_rd;
   end

   // Whole run needs well under 20000 cycles
   initial
   begin
      repeat (60000) @(posedge i_mclk);
      fail_count++;
      end_sim;
   end

   initial
   begin
      logic [31:0] r;
      void'($urandom(32'hb1b0554c));
      repeat (10) @(posedge i_mclk);
      i_reset <= 1'b0;
      for (int a = 0; a < 9; a++) if (a != 1) reg_rd(8'(a * 4), 32'h0);
      reg_wr(8'h20, 32'hffff_ffff);
      reg_rd(8'h20, 32'h0);
      $display("test reset_map done");
      pause <= 1'b1;
      reg_wr(`RSS_OFS_CONTROL, 32'h1);
      load_req(32'h0002_a253, 32'h1234_5670, 16'h2, 16'h8, 16'h0010);
      repeat (4) @(posedge i_mclk);
      reg_rd(`RSS_OFS_OPTIONS, 32'h0002_a253);
      reg_rd(`RSS_OFS_SRC_PTR, 32'h1234_5670);
      reg_rd(`RSS_OFS_COUNTS, 32'h0002_0008);
      reg_rd(`RSS_OFS_STRIDES, 32'h0000_0010);
      reg_wr(`RSS_OFS_SRC_PTR, 32'hdead_beef);
      // rank arrives only with the load; a register write must not move it
      reg_wr(`RSS_OFS_OPTIONS, 32'hffff_ffff);
      reg_rd(`RSS_OFS_SRC_PTR, 32'h1234_5670);
      reg_rd(`RSS_OFS_OPTIONS, 32'h0052_a253);
      reg_wr(`RSS_OFS_CONTROL, 32'h0);
      repeat (4) @(posedge i_mclk);
      reg_rd(`RSS_OFS_COUNTS, 32'h0002_0008);
      pause <= 1'b0;
      wait_done(8'hea);
      reg_rd(`RSS_OFS_COUNTS, 32'h0);
      repeat (2) @(posedge i_mclk);
      `CHK(o_irq, 1'b0)
      reg_wr(`RSS_OFS_IRQ_MASK, 32'h1);
      repeat (2) @(posedge i_mclk);
      `CHK(o_irq, 1'b1)
      reg_rd(`RSS_OFS_IRQ_STATUS, 32'h1);
      reg_wr(`RSS_OFS_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge i_mclk);
      `CHK(o_irq, 1'b0)
      $display("test observe_irq done");
      slow <= 1'b1;
      for (int sz = 0; sz < 5; sz++)
      begin
         load_req(32'h1 | (sz << 8) | (sz << 12), 32'h8000_0000 + sz, 16'h2, 16'h3 << sz, 16'hfff8);
         wait_done(8'(sz));
      end
      load_req(32'hffac_0d8d, 32'h40, 16'h1, 16'h0, 16'h0);
      wait_done(8'h0);
      reg_rd(`RSS_OFS_IRQ_STATUS, 32'h2);
      reg_rd(`RSS_OFS_OPTIONS, 32'h0000_0501);
      reg_wr(`RSS_OFS_IRQ_STATUS, 32'h2);
      $display("test fixed_port done");
      repeat (12)
      begin
         r = $urandom & 32'h0053_f772;
         slow <= 1'($urandom % 2);
         load_req(r, $urandom, 16'(1 + $urandom % 3), 16'($urandom % 200), 16'($urandom));
         wait_done({r[22], r[20], r[17:12]});
      end
      `CHK(exp_cmd.size(), 0)
      $display("test random_requests done");
      end_sim;
   end
endmodule
